// ===== logic/e1_alarm_map.vh
// What this block does
// R1 - frame loss from reset until first sync
// R2 - signal loss after 255/2048/192 zeros
// R3 - clear signal loss: 32 ones per 255
// R4 - remote alarm on three equal bit3 samples
// R5 - all-ones: under three zeros per 512
// R6 - distant mf alarm after two set multiframes
// R7 - v5 link when two of three zero
// R8 - identity: device code high, revision low
// R9 - frame loss bit while not synchronized
// R10 - alarm indication bit during all-ones
// R11 - yellow bit only in t1 mode
// R12 - frame loss clear event until read
// R13 - clear events for los, ais, yellow
// R14 - 6312k mode: signal loss from range
// R15 - mask gates; conditions interrupt on rise
// R16 - output format: bipolar or nrz
// R17 - tx sync pin direction bit
// R18 - tx sync frame or multiframe pulses
// R19 - t1 double-wide tx sync pulse
// R20 - frame loss pin function select
// R21 - rx sync frame or multiframe pulse
// R22 - rx sync double-wide or crc4/cas select
// R23 - alternate criteria selects 255 or 2048
// R24 - manual resync on rising control bit
// R25 - enabled pending bits form one request
`ifndef E1_ALARM_MAP_VH
`define E1_ALARM_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_PIN_CONFIG_ONE 8'h01
`define OFS_CHIP_IDENTITY 8'h10
`define OFS_ALARM_STATUS 8'h16
`define OFS_ALARM_IRQ_MASK 8'h17
`define OFS_E1_RX_CONTROL 8'h1D

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PIN_CONFIG_ONE 8'h00
`define RST_ALARM_IRQ_MASK 8'h00
`define RST_E1_RX_CONTROL 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_LINE_OUT_FORMAT 0
`define BIT_TX_SYNC_DIR 1
`define BIT_TX_SYNC_MODE_SEL 2
`define BIT_TX_SYNC_DOUBLE 3
`define BIT_FRAME_LOSS_PIN_FUNC 4
`define BIT_RX_SYNC_MODE_A 5
`define BIT_RX_SYNC_MODE_B 6
`define BIT_RESYNC 0
`define BIT_SIGNAL_LOSS_ALT 6

// ----------------------------------------
// thresholds in bit times
// ----------------------------------------
`define LOS_ZEROS_E1 12'h0FF
`define LOS_ZEROS_E1_ALT 12'h800
`define LOS_ZEROS_T1 12'h0C0
`define LOS_CLR_WINDOW 8'hFF
`define LOS_CLR_ONES 6'h20
`define AIS_WINDOW 9'h1FF
`define AIS_ZEROS 2'h3

`endif

// ===== logic/e1_rx_alarm_status_pin_config.v
`timescale 1ns/1ps
`include "e1_alarm_map.vh"

module e1_rx_alarm_status_pin_config #(
   parameter [3:0] DEVICE_CODE = 4'h9, // arbitrary value
   parameter [3:0] DIE_REV = 4'h0
) (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_n_i,
   // register port
   input wire [7:0] addr_i,
   input wire [7:0] wr_data_i,
   input wire wr_stb_i,
   input wire rd_stb_i,
   output reg [7:0] rd_data_o,
   output wire irq_o,
   // modes
   input wire t1_mode_i,
   input wire mode_6312_i,
   // receive stream and framer
   input wire rx_bit_stb_i,
   input wire rx_bit_i,
   input wire sync_found_i,
   input wire resync_crit_i,
   output reg resync_req_o,
   input wire nfas_stb_i,
   input wire nfas_bit3_i,
   input wire mf_ts16_stb_i,
   input wire mf_ts16_bit6_i,
   input wire sa7_stb_i,
   input wire sa7_i,
   input wire yellow_i,
   input wire out_of_range_i,
   input wire tx_clock_loss_i,
   // alarm outputs
   output wire rx_remote_alarm_o,
   output wire rx_distant_mf_alarm_o,
   output wire v5_link_detect_o,
   output reg frame_loss_pin_o,
   // receive sync
   input wire rx_frame_pulse_i,
   input wire rx_mf_pulse_i,
   input wire rx_crc4_mf_pulse_i,
   input wire rx_sig_frame_i,
   output reg rx_sync_pin_o,
   // transmit sync
   input wire tx_frame_pulse_i,
   input wire tx_mf_pulse_i,
   input wire tx_sig_frame_i,
   input wire tx_sync_pin_i,
   output reg tx_sync_pin_o,
   output wire tx_sync_pin_oe_o,
   output wire tx_sync_in_o,
   output wire tx_sync_in_mf_o,
   // line output
   input wire tx_bip_pos_i,
   input wire tx_bip_neg_i,
   input wire tx_nrz_i,
   output reg line_out_pos_o,
   output reg line_out_neg_o
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [1:0] zeros3;
      input [2:0] v;
      begin
         zeros3 = {1'b0, ~v[0]} + {1'b0, ~v[1]} + {1'b0, ~v[2]};
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] pin_config_one_ff;
   reg [7:0] alarm_irq_mask_ff;
   reg [7:0] e1_rx_control_ff;
   reg resync_bit_ff;
   wire wr_cfg = wr_stb_i && addr_i == `OFS_PIN_CONFIG_ONE;
   wire wr_msk = wr_stb_i && addr_i == `OFS_ALARM_IRQ_MASK;
   wire wr_ctl = wr_stb_i && addr_i == `OFS_E1_RX_CONTROL;
   wire rd_sts = rd_stb_i && addr_i == `OFS_ALARM_STATUS;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pin_config_one_ff <= `RST_PIN_CONFIG_ONE;
         alarm_irq_mask_ff <= `RST_ALARM_IRQ_MASK;
         e1_rx_control_ff <= `RST_E1_RX_CONTROL;
      end else begin
         if (wr_cfg) begin
            pin_config_one_ff <= wr_data_i;
         end
         if (wr_msk) begin
            alarm_irq_mask_ff <= wr_data_i;
         end
         if (wr_ctl) begin
            e1_rx_control_ff <= wr_data_i;
         end
      end
   end

   wire out_nrz = pin_config_one_ff[`BIT_LINE_OUT_FORMAT];
   wire txs_dir = pin_config_one_ff[`BIT_TX_SYNC_DIR];
   wire txs_mode = pin_config_one_ff[`BIT_TX_SYNC_MODE_SEL];
   wire txs_dbl = pin_config_one_ff[`BIT_TX_SYNC_DOUBLE];
   wire lof_func = pin_config_one_ff[`BIT_FRAME_LOSS_PIN_FUNC];
   wire rxs_a = pin_config_one_ff[`BIT_RX_SYNC_MODE_A];
   wire rxs_b = pin_config_one_ff[`BIT_RX_SYNC_MODE_B];
   wire los_alt = e1_rx_control_ff[`BIT_SIGNAL_LOSS_ALT];

   // ----------------------------------------
   // frame loss
   // ----------------------------------------
   reg frame_loss_ff;
   // R24 rising resync bit
   wire manual_resync = e1_rx_control_ff[`BIT_RESYNC] && !resync_bit_ff;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         // R1 set at power-up
         frame_loss_ff <= 1'b1;
         resync_bit_ff <= 1'b0;
         resync_req_o <= 1'b0;
      end else begin
         resync_bit_ff <= e1_rx_control_ff[`BIT_RESYNC];
         resync_req_o <= manual_resync;
         // R1 resync sets, sync clears
         if (manual_resync || resync_crit_i) begin
            frame_loss_ff <= 1'b1;
         end else if (sync_found_i) begin
            frame_loss_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // signal loss
   // ----------------------------------------
   reg [11:0] zero_run_ff;
   reg [7:0] win_ff;
   reg [5:0] ones_ff;
   reg los_ff;
   reg [11:0] los_limit;

   always @* begin
      // R2 mode threshold
      if (t1_mode_i) begin
         los_limit = `LOS_ZEROS_T1;
      // R23 alternate criteria
      end else if (los_alt) begin
         los_limit = `LOS_ZEROS_E1_ALT;
      end else begin
         los_limit = `LOS_ZEROS_E1;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         zero_run_ff <= 12'h000;
         win_ff <= 8'h00;
         ones_ff <= 6'h00;
         los_ff <= 1'b0;
      end else if (rx_bit_stb_i) begin
         if (rx_bit_i) begin
            zero_run_ff <= 12'h000;
         end else if (zero_run_ff != 12'hFFF) begin
            zero_run_ff <= zero_run_ff + 12'h001;
         end
         // R3 block window of ones
         if (win_ff == `LOS_CLR_WINDOW - 8'h01) begin
            win_ff <= 8'h00;
            ones_ff <= 6'h00;
         end else begin
            win_ff <= win_ff + 8'h01;
            if (rx_bit_i && ones_ff != `LOS_CLR_ONES) begin
               ones_ff <= ones_ff + 6'h01;
            end
         end
         // R2 zero run reaches limit
         if (!rx_bit_i && zero_run_ff + 12'h001 >= los_limit) begin
            los_ff <= 1'b1;
         // R3 enough ones in window
         end else if (rx_bit_i && ones_ff + 6'h01 >= `LOS_CLR_ONES) begin
            los_ff <= 1'b0;
         end
      end
   end

   // R14 range check in 6312k mode
   wire sig_loss = mode_6312_i ? out_of_range_i : los_ff;

   // ----------------------------------------
   // remote alarm
   // ----------------------------------------
   reg [1:0] ra_run_ff;
   reg ra_last_ff;
   reg ra_ff;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ra_run_ff <= 2'h0;
         ra_last_ff <= 1'b0;
         ra_ff <= 1'b0;
      end else if (nfas_stb_i) begin
         ra_last_ff <= nfas_bit3_i;
         if (nfas_bit3_i != ra_last_ff) begin
            ra_run_ff <= 2'h1;
         end else if (ra_run_ff != 2'h3) begin
            ra_run_ff <= ra_run_ff + 2'h1;
         end
         // R4 third equal sample
         if (nfas_bit3_i == ra_last_ff && ra_run_ff == 2'h2) begin
            ra_ff <= nfas_bit3_i;
         end
      end
   end
   assign rx_remote_alarm_o = ra_ff;

   // ----------------------------------------
   // unframed all-ones
   // ----------------------------------------
   reg [8:0] ais_win_ff;
   reg [1:0] ais_zeros_ff;
   reg ais_ff;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ais_win_ff <= 9'h000;
         ais_zeros_ff <= 2'h0;
         ais_ff <= 1'b0;
      end else if (rx_bit_stb_i) begin
         if (ais_win_ff == `AIS_WINDOW) begin
            ais_win_ff <= 9'h000;
            ais_zeros_ff <= 2'h0;
            // R5 judge two frames; the count saturates, so compare, never add
            ais_ff <= ais_zeros_ff < `AIS_ZEROS - 2'h1
               || (ais_zeros_ff == `AIS_ZEROS - 2'h1 && rx_bit_i);
         end else begin
            ais_win_ff <= ais_win_ff + 9'h001;
            if (!rx_bit_i && ais_zeros_ff != `AIS_ZEROS) begin
               ais_zeros_ff <= ais_zeros_ff + 2'h1;
            end
         end
      end
   end

   // ----------------------------------------
   // distant mf alarm and v5 link
   // ----------------------------------------
   reg dma_prev_ff;
   reg dma_ff;
   reg [2:0] sa7_ff;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         dma_prev_ff <= 1'b0;
         dma_ff <= 1'b0;
         sa7_ff <= 3'h7;
      end else begin
         if (mf_ts16_stb_i) begin
            dma_prev_ff <= mf_ts16_bit6_i;
            // R6 two set multiframes
            dma_ff <= mf_ts16_bit6_i && dma_prev_ff;
         end
         if (sa7_stb_i) begin
            sa7_ff <= {sa7_ff[1:0], sa7_i};
         end
      end
   end
   assign rx_distant_mf_alarm_o = dma_ff;
   // R7 two of three zero
   assign v5_link_detect_o = zeros3(sa7_ff) >= 2'h2;

   // ----------------------------------------
   // status and interrupt
   // ----------------------------------------
   // R9 R10 R11 condition bits
   wire [3:0] cond = {t1_mode_i && yellow_i, ais_ff, sig_loss, frame_loss_ff};
   reg [3:0] cond_ff;
   reg [3:0] evt_ff;
   reg [3:0] rise_ff;
   wire [3:0] fall = cond_ff & ~cond;
   wire [3:0] rise = cond & ~cond_ff;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cond_ff <= 4'h1;
         evt_ff <= 4'h0;
         rise_ff <= 4'h0;
      end else begin
         cond_ff <= cond;
         // R12 R13 set wins over read clear
         evt_ff <= fall | (rd_sts ? 4'h0 : evt_ff);
         // R15 edge pending for conditions
         rise_ff <= rise | (rd_sts ? 4'h0 : rise_ff);
      end
   end

   wire [7:0] alarm_status = {evt_ff, cond};
   // R15 R25 mask gate and merge
   assign irq_o = |({evt_ff, rise_ff} & alarm_irq_mask_ff);

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rd_data_o <= 8'h00;
      end else if (rd_stb_i) begin
         case (addr_i)
            `OFS_PIN_CONFIG_ONE: begin
               rd_data_o <= pin_config_one_ff;
            end
            // R8 code and revision
            `OFS_CHIP_IDENTITY: begin
               rd_data_o <= {DEVICE_CODE, DIE_REV};
            end
            `OFS_ALARM_STATUS: begin
               rd_data_o <= alarm_status;
            end
            `OFS_ALARM_IRQ_MASK: begin
               rd_data_o <= alarm_irq_mask_ff;
            end
            `OFS_E1_RX_CONTROL: begin
               rd_data_o <= e1_rx_control_ff;
            end
            default: begin
               rd_data_o <= 8'h00;
            end
         endcase
      end else begin
         rd_data_o <= 8'h00;
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   reg txs_meta_ff;
   reg txs_sync_ff;
   reg txs_ext_ff;
   reg rxs_ext_ff;
   // R18 6312k mode forces frame pulses
   wire txs_mf = txs_mode && !mode_6312_i;
   wire txs_pulse = txs_mf ? tx_mf_pulse_i : tx_frame_pulse_i;
   // R19 t1 only, output only
   wire txs_wide = t1_mode_i && txs_dbl && txs_dir && tx_sig_frame_i;
   wire rxs_wide = t1_mode_i && !rxs_a && rxs_b && rx_sig_frame_i;
   reg rxs_pulse;

   always @* begin
      // R21 R22 receive sync selection
      if (!rxs_a) begin
         rxs_pulse = rx_frame_pulse_i;
      end else if (!t1_mode_i && rxs_b) begin
         rxs_pulse = rx_crc4_mf_pulse_i;
      end else begin
         rxs_pulse = rx_mf_pulse_i;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         txs_meta_ff <= 1'b0;
         txs_sync_ff <= 1'b0;
         txs_ext_ff <= 1'b0;
         rxs_ext_ff <= 1'b0;
         tx_sync_pin_o <= 1'b0;
         rx_sync_pin_o <= 1'b0;
         frame_loss_pin_o <= 1'b1;
         line_out_pos_o <= 1'b0;
         line_out_neg_o <= 1'b0;
      end else begin
         txs_meta_ff <= tx_sync_pin_i;
         txs_sync_ff <= txs_meta_ff;
         // second clock of a wide pulse
         txs_ext_ff <= txs_pulse && txs_wide;
         rxs_ext_ff <= rxs_pulse && rxs_wide;
         // R18 R19 transmit sync drive
         tx_sync_pin_o <= txs_pulse || txs_ext_ff;
         rx_sync_pin_o <= rxs_pulse || rxs_ext_ff;
         // R20 pin function
         frame_loss_pin_o <= lof_func ? tx_clock_loss_i : frame_loss_ff;
         // R16 nrz holds negative low
         line_out_pos_o <= out_nrz ? tx_nrz_i : tx_bip_pos_i;
         line_out_neg_o <= out_nrz ? 1'b0 : tx_bip_neg_i;
      end
   end

   // R17 direction bit
   assign tx_sync_pin_oe_o = txs_dir;
   // input sync is blanked while driving
   assign tx_sync_in_o = txs_sync_ff && !txs_dir;
   assign tx_sync_in_mf_o = txs_mf;

endmodule // e1_rx_alarm_status_pin_config

// ===== tb/e1_rx_alarm_properties.sv
`timescale 1ns/1ps
module e1_rx_alarm_checker #(
   parameter [3:0] DEVICE_CODE = 4'h9
) (
   // clock, reset and register port
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [7:0] wr_data_i,
   input wire wr_stb_i,
   input wire rd_stb_i,
   input wire [7:0] rd_data_o,
   input wire irq_o,
   // alarm samples and results
   input wire nfas_stb_i,
   input wire nfas_bit3_i,
   input wire mf_ts16_stb_i,
   input wire mf_ts16_bit6_i,
   input wire sa7_stb_i,
   input wire sa7_i,
   input wire rx_remote_alarm_o,
   input wire rx_distant_mf_alarm_o,
   input wire v5_link_detect_o,
   input wire resync_req_o,
   // pins
   input wire line_out_neg_o,
   input wire tx_sync_pin_oe_o
);
   // shadows of the writable bits, so pin rules can be judged from the port
   reg [7:0] cfg_ff;
   reg [7:0] mask_ff;
   reg resync_ff;
   reg [2:0] sa7_ff;
   wire [2:0] zero_v = ~sa7_ff;
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cfg_ff <= 8'h00;
         mask_ff <= 8'h00;
         resync_ff <= 1'b0;
         sa7_ff <= 3'h7;
      end else begin
         if (wr_stb_i && addr_i == 8'h01) cfg_ff <= wr_data_i;
         if (wr_stb_i && addr_i == 8'h17) mask_ff <= wr_data_i;
         if (wr_stb_i && addr_i == 8'h1D) resync_ff <= wr_data_i[0];
         if (sa7_stb_i) sa7_ff <= {sa7_ff[1:0], sa7_i};
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   id_read_a: assert property (rd_stb_i && addr_i == 8'h10 |=> rd_data_o[7:4] == DEVICE_CODE)
      else $error("identity code wrong");
   nrz_neg_a: assert property (cfg_ff[0] |=> !line_out_neg_o)
      else $error("negative output not low in nrz");
   sync_dir_a: assert property (tx_sync_pin_oe_o == cfg_ff[1])
      else $error("sync pin direction wrong");
   resync_pulse_a: assert property (wr_stb_i && addr_i == 8'h1D && wr_data_i[0] && !resync_ff
      |-> ##[1:2] resync_req_o ##1 !resync_req_o)
      else $error("manual resync pulse missing");
   v5_vote_a: assert property (v5_link_detect_o == (zero_v[0] & zero_v[1] | zero_v[0] & zero_v[2]
      | zero_v[1] & zero_v[2]))
      else $error("link detect vote wrong");
   remote_set_a: assert property ($rose(rx_remote_alarm_o) |-> $past(nfas_stb_i && nfas_bit3_i))
      else $error("remote alarm rose without sample");
   dma_set_a: assert property ($rose(rx_distant_mf_alarm_o) |-> $past(mf_ts16_stb_i && mf_ts16_bit6_i))
      else $error("multiframe alarm rose without sample");
   irq_masked_a: assert property (mask_ff == 8'h00 |-> !irq_o)
      else $error("request while all masked");
   cover property (resync_req_o);
   cover property (v5_link_detect_o);
   cover property (irq_o);
endmodule // e1_rx_alarm_checker

bind e1_rx_alarm_status_pin_config e1_rx_alarm_checker #(.DEVICE_CODE(DEVICE_CODE)) u_e1_rx_alarm_checker (.*);

// ===== tb/line_source.sv
`timescale 1ns/1ps
module line_source (
   // clock
   input wire clk_sys_i,
   // command from the bench
   input wire go_i,
   input wire val_i,
   input wire [11:0] count_i,
   // received line
   output reg bit_stb_o,
   output reg bit_o,
   output wire busy_o
);
   reg [11:0] left_ff = 12'h000;
   reg ph_ff = 1'b0;
   assign busy_o = left_ff != 12'h000;
   initial begin
      bit_stb_o = 1'b0;
      bit_o = 1'b0;
   end
   // one bit every second clock; between bits the data line shows the inverse
   always @(posedge clk_sys_i) begin
      if (go_i) begin
         left_ff <= count_i;
         ph_ff <= 1'b0;
         bit_stb_o <= 1'b0;
      end else if (busy_o) begin
         ph_ff <= ~ph_ff;
         bit_stb_o <= ph_ff;
         bit_o <= ph_ff ? val_i : ~val_i;
         if (ph_ff) left_ff <= left_ff - 12'h001;
      end else begin
         bit_stb_o <= 1'b0;
         bit_o <= ~bit_o;
      end
   end
endmodule // line_source

// ===== tb/e1_rx_alarm_status_pin_config_tb_top.sv
`timescale 1ns/1ps
module e1_rx_alarm_status_pin_config_tb_top;
   reg clk_sys_i = 1'b0, rst_n_i = 1'b0;
   reg [7:0] addr_i = 8'h00, wr_data_i = 8'h00, cnt_ff = 8'h00, d;
   reg wr_stb_i = 1'b0, rd_stb_i = 1'b0, t1_mode_i = 1'b0, mode_6312_i = 1'b0;
   reg sync_found_i = 1'b0, resync_crit_i = 1'b0, yellow_i = 1'b0, out_of_range_i = 1'b0;
   reg [2:0] stb_v = 3'h0;
   reg samp_v = 1'b0, go_v = 1'b0, val_v = 1'b0;
   reg [11:0] num_v = 12'h000;
   integer n_errors = 0, num_checks = 0;
   wire nfas_stb_i = stb_v[0], mf_ts16_stb_i = stb_v[1], sa7_stb_i = stb_v[2];
   wire nfas_bit3_i = samp_v, mf_ts16_bit6_i = samp_v, sa7_i = samp_v;
   wire tx_clock_loss_i = cnt_ff[7], rx_frame_pulse_i = cnt_ff[3:0] == 4'h0, rx_mf_pulse_i = cnt_ff == 8'h00;
   wire rx_crc4_mf_pulse_i = cnt_ff == 8'h80, rx_sig_frame_i = cnt_ff[5], tx_frame_pulse_i = cnt_ff[3:0] == 4'h8;
   wire tx_mf_pulse_i = cnt_ff == 8'h40, tx_sig_frame_i = cnt_ff[6];
   wire tx_bip_pos_i = cnt_ff[0], tx_bip_neg_i = cnt_ff[1], tx_nrz_i = cnt_ff[2];
   wire rx_bit_stb_i, rx_bit_i, line_busy, irq_o, resync_req_o, rx_remote_alarm_o, rx_distant_mf_alarm_o;
   wire v5_link_detect_o, frame_loss_pin_o, rx_sync_pin_o, tx_sync_pin_o, tx_sync_pin_oe_o, tx_sync_in_o;
   wire tx_sync_in_mf_o, line_out_pos_o, line_out_neg_o;
   wire [7:0] rd_data_o;
   // the sync pin level: our drive when the design does not drive it
   wire tx_sync_pin_i = tx_sync_pin_oe_o ? tx_sync_pin_o : cnt_ff[4];

   e1_rx_alarm_status_pin_config #(.DEVICE_CODE(4'h6), .DIE_REV(4'h3)) u_e1_rx_alarm_status_pin_config (.*);
   line_source u_line_source (.clk_sys_i(clk_sys_i), .go_i(go_v), .val_i(val_v), .count_i(num_v),
      .bit_stb_o(rx_bit_stb_i), .bit_o(rx_bit_i), .busy_o(line_busy));

   always #10 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) cnt_ff <= cnt_ff + 8'h01;

   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task chk(input [8*8-1:0] name, input [7:0] exp, input [7:0] got);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected %0s exp %h got %h", name, exp, got);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] v);
      begin
         addr_i <= a;
         wr_data_i <= v;
         wr_stb_i <= 1'b1;
         @(posedge clk_sys_i);
         wr_stb_i <= 1'b0;
         @(posedge clk_sys_i);
      end
   endtask
   task rd(input [7:0] a);
      begin
         addr_i <= a;
         rd_stb_i <= 1'b1;
         @(posedge clk_sys_i);
         rd_stb_i <= 1'b0;
         #1 d = rd_data_o;
         @(posedge clk_sys_i);
      end
   endtask
   task bits(input v, input [11:0] n);
      begin
         go_v <= 1'b1;
         val_v <= v;
         num_v <= n;
         @(posedge clk_sys_i);
         go_v <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
         while (line_busy) @(posedge clk_sys_i);
         repeat (3) @(posedge clk_sys_i);
      end
   endtask
   task strb(input [2:0] w, input v, input [7:0] exp);
      begin
         stb_v <= w;
         samp_v <= v;
         @(posedge clk_sys_i);
         stb_v <= 3'h0;
         @(posedge clk_sys_i);
         #1 chk("alarm", exp, {5'h0, v5_link_detect_o, rx_distant_mf_alarm_o, rx_remote_alarm_o});
      end
   endtask
   // waits for the free-running counter, then looks 1 ns past the edge
   task at_cnt(input [7:0] c);
      begin
         @(posedge clk_sys_i);
         #1;
         while (cnt_ff !== c) begin
            @(posedge clk_sys_i);
            #1;
         end
      end
   endtask
   task pulse_sync(input crit);
      begin
         sync_found_i <= !crit;
         resync_crit_i <= crit;
         @(posedge clk_sys_i);
         sync_found_i <= 1'b0;
         resync_crit_i <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
      begin
         rd(8'h01); chk("cfg", 8'h00, d);
         rd(8'h17); chk("mask", 8'h00, d);
         rd(8'h16); chk("status", 8'h01, d);
         wr(8'h10, 8'hFF);
         rd(8'h10); chk("ident", 8'h63, d);
         rd(8'h3F); chk("unmapped", 8'h00, d);
      end
   endtask
   task t_los(input t1, input alt, input [11:0] n);
      begin
         t1_mode_i <= t1;
         wr(8'h1D, alt ? 8'h40 : 8'h00);
         bits(1'b1, 12'h1FE);
         bits(1'b0, n - 12'h001);
         rd(8'h16); chk("los", 8'h00, d & 8'h02);
         bits(1'b0, 12'h001);
         chk("irq", 8'h01, {7'h0, irq_o});
         rd(8'h16); chk("los", 8'h02, d & 8'h02);
         chk("irq", 8'h00, {7'h0, irq_o});
         bits(1'b1, 12'h1FE);
         rd(8'h16); chk("los clr", 8'h20, d & 8'h22);
      end
   endtask
   task t_ais;
      begin
         bits(1'b1, 12'h44C);
         rd(8'h16); chk("ais", 8'h04, d & 8'h04);
         bits(1'b0, 12'h258);
         rd(8'h16); chk("ais clr", 8'h40, d & 8'h44);
      end
   endtask
   task t_frame;
      begin
         pulse_sync(1'b0);
         rd(8'h16); chk("lof clr", 8'h10, d & 8'h11);
         rd(8'h16); chk("lof read", 8'h00, d & 8'h11);
         wr(8'h1D, 8'h01);
         rd(8'h16); chk("resync", 8'h01, d & 8'h01);
         wr(8'h1D, 8'h00);
         pulse_sync(1'b0);
         pulse_sync(1'b1);
         rd(8'h16); chk("crit", 8'h01, d & 8'h01);
      end
   endtask
   task t_samples;
      begin
         strb(3'h1, 1'b1, 8'h00);
         strb(3'h1, 1'b1, 8'h00);
         strb(3'h1, 1'b1, 8'h01);
         strb(3'h1, 1'b0, 8'h01);
         strb(3'h1, 1'b0, 8'h01);
         strb(3'h1, 1'b0, 8'h00);
         strb(3'h2, 1'b1, 8'h00);
         strb(3'h2, 1'b1, 8'h02);
         strb(3'h4, 1'b0, 8'h02);
         strb(3'h4, 1'b0, 8'h06);
      end
   endtask
   task t_modes;
      begin
         @(posedge clk_sys_i);
         wr(8'h17, 8'h80);
         t1_mode_i <= 1'b1;
         yellow_i <= 1'b1;
         rd(8'h16); chk("yellow", 8'h08, d & 8'h08);
         yellow_i <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
         chk("irq evt", 8'h01, {7'h0, irq_o});
         rd(8'h16); chk("yel clr", 8'h80, d & 8'h88);
         chk("irq evt", 8'h00, {7'h0, irq_o});
         t1_mode_i <= 1'b0;
         yellow_i <= 1'b1;
         rd(8'h16); chk("yel e1", 8'h00, d & 8'h08);
         yellow_i <= 1'b0;
         wr(8'h17, 8'h00);
         // sync mode and loss pin function stay 0 in 6312k mode
         mode_6312_i <= 1'b1;
         rd(8'h16); chk("range", 8'h00, d & 8'h02);
         out_of_range_i <= 1'b1;
         rd(8'h16); chk("range", 8'h02, d & 8'h02);
         mode_6312_i <= 1'b0;
         out_of_range_i <= 1'b0;
      end
   endtask
   task t_pins;
      begin
         wr(8'h01, 8'h13);
         at_cnt(8'h05);
         chk("pos nrz", 8'h01, {7'h0, line_out_pos_o});
         chk("neg", 8'h00, {7'h0, line_out_neg_o});
         chk("oe", 8'h01, {7'h0, tx_sync_pin_oe_o});
         at_cnt(8'h09);
         chk("txs out", 8'h01, {7'h0, tx_sync_pin_o});
         chk("txs in", 8'h00, {7'h0, tx_sync_in_o});
         at_cnt(8'h0A);
         chk("txs out", 8'h00, {7'h0, tx_sync_pin_o});
         at_cnt(8'h81);
         chk("lof pin", 8'h01, {7'h0, frame_loss_pin_o});
         chk("rxs pin", 8'h01, {7'h0, rx_sync_pin_o});
         at_cnt(8'h01);
         chk("lof pin", 8'h00, {7'h0, frame_loss_pin_o});
         @(posedge clk_sys_i);
         t1_mode_i <= 1'b1;
         wr(8'h01, 8'h4A);
         at_cnt(8'h4A);
         chk("txs wide", 8'h01, {7'h0, tx_sync_pin_o});
         chk("pos bip", 8'h01, {7'h0, line_out_pos_o});
         at_cnt(8'h0A);
         chk("txs wide", 8'h00, {7'h0, tx_sync_pin_o});
         at_cnt(8'h22);
         chk("rxs wide", 8'h01, {7'h0, rx_sync_pin_o});
         at_cnt(8'h02);
         chk("rxs wide", 8'h00, {7'h0, rx_sync_pin_o});
         // double-wide bit kept 0 once back in e1
         @(posedge clk_sys_i);
         t1_mode_i <= 1'b0;
         wr(8'h01, 8'h64);
         at_cnt(8'h81);
         chk("rxs crc4", 8'h01, {7'h0, rx_sync_pin_o});
         at_cnt(8'h01);
         chk("rxs crc4", 8'h00, {7'h0, rx_sync_pin_o});
         at_cnt(8'h41);
         chk("txs mf", 8'h01, {7'h0, tx_sync_pin_o});
         chk("txs mf", 8'h01, {7'h0, tx_sync_in_mf_o});
         at_cnt(8'h12);
         chk("txs in", 8'h01, {7'h0, tx_sync_in_o});
         at_cnt(8'h02);
         chk("txs in", 8'h00, {7'h0, tx_sync_in_o});
         @(posedge clk_sys_i);
         wr(8'h01, 8'h20);
         at_cnt(8'h01);
         chk("rxs mf", 8'h01, {7'h0, rx_sync_pin_o});
         @(posedge clk_sys_i);
         rd(8'h01); chk("cfg", 8'h20, d);
      end
   endtask

   task close_out;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_regs;
      wr(8'h17, 8'h02);
      t_los(1'b0, 1'b0, 12'h0FF);
      t_los(1'b0, 1'b1, 12'h800);
      t_los(1'b1, 1'b0, 12'h0C0);
      t1_mode_i <= 1'b0;
      wr(8'h17, 8'h00);
      t_ais;
      t_frame;
      t_samples;
      t_modes;
      t_pins;
      close_out;
   end

   // hang guard: the full sequence needs roughly 17000 cycles
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      n_errors = n_errors + 1;
      close_out;
   end
endmodule // e1_rx_alarm_status_pin_config_tb_top
